// ---- flash_status_pkg.sv ----
/*
 * constants for the serial flash status register and write-enable gate:
 * status bit layout, reset value, instruction opcodes, default busy time.
 * assumes nothing of its surroundings; used with explicit package scope.
 */
package flash_status_pkg;

  // status register layout
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam int         BUSY_BIT          = 0;
  localparam int         WEL_BIT           = 1;
  localparam int         PROT_LSB          = 2;
  localparam int         PROT_MSB          = 5;
  localparam int         FOUR_LINE_BIT     = 6;
  localparam int         STATUS_LOCK_BIT   = 7;
  localparam logic [5:0] STATUS_NV_RESET   = 6'h00;

  // length of one internal write cycle in system clocks (no array model)
  localparam int         BUSY_CYCLES_DEF   = 1000;

  // read, reset, suspend and latch instructions
  localparam logic [7:0] OP_READ_STATUS    = 8'h05;
  localparam logic [7:0] OP_RESET_ENABLE   = 8'h66;
  localparam logic [7:0] OP_RESET          = 8'h99;
  localparam logic [7:0] OP_SUSPEND        = 8'h75;
  localparam logic [7:0] OP_RESUME         = 8'h7a;
  localparam logic [7:0] OP_SET_WEL        = 8'h06;
  localparam logic [7:0] OP_CLEAR_WEL      = 8'h04;

  // program instructions
  localparam logic [7:0] OP_PP             = 8'h02;
  localparam logic [7:0] OP_PP4            = 8'h12;
  localparam logic [7:0] OP_PPQ_A          = 8'h32;
  localparam logic [7:0] OP_PPQ_B          = 8'h38;
  localparam logic [7:0] OP_PPQ4_A         = 8'h34;
  localparam logic [7:0] OP_PPQ4_B         = 8'h3e;

  // erase instructions
  localparam logic [7:0] OP_SE_A           = 8'hd7;
  localparam logic [7:0] OP_SE_B           = 8'h20;
  localparam logic [7:0] OP_SE4            = 8'h21;
  localparam logic [7:0] OP_BE32           = 8'h52;
  localparam logic [7:0] OP_BE32_4         = 8'h5c;
  localparam logic [7:0] OP_BE64           = 8'hd8;
  localparam logic [7:0] OP_BE64_4         = 8'hdc;
  localparam logic [7:0] OP_CE_A           = 8'hc7;
  localparam logic [7:0] OP_CE_B           = 8'h60;

  // register writes, non-volatile
  localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
  localparam logic [7:0] OP_WRITE_FUNC     = 8'h42;
  localparam logic [7:0] OP_RDPARAM_NV     = 8'h65;
  localparam logic [7:0] OP_XRDPARAM_NV    = 8'h85;
  localparam logic [7:0] OP_INFO_ERASE     = 8'h64;
  localparam logic [7:0] OP_INFO_PROG      = 8'h62;
  localparam logic [7:0] OP_BANK_NV        = 8'h18;
  localparam logic [7:0] OP_TRAIN_NV       = 8'h43;

  // register writes, volatile (latch gated, no internal cycle)
  localparam logic [7:0] OP_XRDPARAM_V     = 8'h83;
  localparam logic [7:0] OP_TRAIN_V        = 8'h4a;
  localparam logic [7:0] OP_DYN_GUARD      = 8'hfb;
  localparam logic [7:0] OP_DYN_GUARD4     = 8'he1;

  // sector guard writes, non-volatile
  localparam logic [7:0] OP_PERS_GUARD     = 8'hfd;
  localparam logic [7:0] OP_PERS_GUARD4    = 8'he3;
  localparam logic [7:0] OP_PERS_ERASE     = 8'he4;
  localparam logic [7:0] OP_PROG_ASP       = 8'h2f;
  localparam logic [7:0] OP_GUARD_LOCK     = 8'ha6;
  localparam logic [7:0] OP_FREEZE         = 8'h91;
  localparam logic [7:0] OP_GANG_LOCK      = 8'h7e;
  localparam logic [7:0] OP_GANG_UNLOCK    = 8'h98;
  localparam logic [7:0] OP_PROG_PASSWORD  = 8'he8;

  // volatile writes that need no latch
  localparam logic [7:0] OP_RDPARAM_V      = 8'hc0;
  localparam logic [7:0] OP_RDPARAM_V_ALT  = 8'h63;
  localparam logic [7:0] OP_BANK_V         = 8'h17;
  localparam logic [7:0] OP_BANK_V_ALT     = 8'hc5;

endpackage

// ---- flash_status_and_write_enable.sv ----
/*
 * status register, busy flag and write-enable latch of a serial flash,
 * reached over the serial pins (mode 0 or 3, single line).
 * assumes sck, cs_n, si and wp_n come from outside the sys_clk domain
 * and toggle no faster than a quarter of sys_clk; array itself not modelled.
 */
`timescale 1ns/10ps
module flash_status_and_write_enable #(
  parameter int BUSY_CYCLES = flash_status_pkg::BUSY_CYCLES_DEF
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  output logic      so,
  output logic      so_oe,
  output logic      four_line_enable,
  output logic      busy_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // opcode classes
  // latch-gated opcodes only
  function automatic logic is_gated(input logic [7:0] op);
    case (op)
      flash_status_pkg::OP_PP, flash_status_pkg::OP_PP4, flash_status_pkg::OP_PPQ_A,
      flash_status_pkg::OP_PPQ_B, flash_status_pkg::OP_PPQ4_A, flash_status_pkg::OP_PPQ4_B,
      flash_status_pkg::OP_SE_A, flash_status_pkg::OP_SE_B, flash_status_pkg::OP_SE4,
      flash_status_pkg::OP_BE32, flash_status_pkg::OP_BE32_4, flash_status_pkg::OP_BE64,
      flash_status_pkg::OP_BE64_4, flash_status_pkg::OP_CE_A, flash_status_pkg::OP_CE_B,
      flash_status_pkg::OP_WRITE_STATUS, flash_status_pkg::OP_WRITE_FUNC,
      flash_status_pkg::OP_RDPARAM_NV, flash_status_pkg::OP_XRDPARAM_NV,
      flash_status_pkg::OP_XRDPARAM_V, flash_status_pkg::OP_INFO_ERASE,
      flash_status_pkg::OP_INFO_PROG, flash_status_pkg::OP_BANK_NV,
      flash_status_pkg::OP_DYN_GUARD, flash_status_pkg::OP_DYN_GUARD4,
      flash_status_pkg::OP_PERS_GUARD, flash_status_pkg::OP_PERS_GUARD4,
      flash_status_pkg::OP_PERS_ERASE, flash_status_pkg::OP_PROG_ASP,
      flash_status_pkg::OP_GUARD_LOCK, flash_status_pkg::OP_FREEZE,
      flash_status_pkg::OP_GANG_LOCK, flash_status_pkg::OP_GANG_UNLOCK,
      flash_status_pkg::OP_PROG_PASSWORD, flash_status_pkg::OP_TRAIN_NV,
      flash_status_pkg::OP_TRAIN_V: is_gated = 1'b1;
      default: is_gated = 1'b0;
    endcase
  endfunction

  // gated opcodes that write volatile cells only: no internal cycle
  function automatic logic is_volatile(input logic [7:0] op);
    case (op)
      flash_status_pkg::OP_XRDPARAM_V, flash_status_pkg::OP_TRAIN_V,
      flash_status_pkg::OP_DYN_GUARD, flash_status_pkg::OP_DYN_GUARD4: is_volatile = 1'b1;
      default: is_volatile = 1'b0;
    endcase
  endfunction

  // program and erase opcodes, the only ones that can be suspended
  function automatic logic is_prog_erase(input logic [7:0] op);
    case (op)
      flash_status_pkg::OP_PP, flash_status_pkg::OP_PP4, flash_status_pkg::OP_PPQ_A,
      flash_status_pkg::OP_PPQ_B, flash_status_pkg::OP_PPQ4_A, flash_status_pkg::OP_PPQ4_B,
      flash_status_pkg::OP_SE_A, flash_status_pkg::OP_SE_B, flash_status_pkg::OP_SE4,
      flash_status_pkg::OP_BE32, flash_status_pkg::OP_BE32_4, flash_status_pkg::OP_BE64,
      flash_status_pkg::OP_BE64_4, flash_status_pkg::OP_CE_A,
      flash_status_pkg::OP_CE_B: is_prog_erase = 1'b1;
      default: is_prog_erase = 1'b0;
    endcase
  endfunction

  function automatic logic is_chip_erase(input logic [7:0] op);
    is_chip_erase = (op == flash_status_pkg::OP_CE_A) || (op == flash_status_pkg::OP_CE_B);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sck_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] si_s_q;
  logic [1:0] wp_s_q;

  // two flops per pin; third flop of sck and cs only feeds edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_s_q <= 3'h0;
      cs_s_q  <= 3'h7;
      si_s_q  <= 2'h0;
      wp_s_q  <= 2'h3;
    end else begin
      sck_s_q <= {sck_s_q[1:0], sck};
      cs_s_q  <= {cs_s_q[1:0], cs_n};
      si_s_q  <= {si_s_q[0], si};
      wp_s_q  <= {wp_s_q[0], wp_n};
    end
  end

  logic sck_rise_w;
  logic sck_fall_w;
  logic sel_w;
  logic cs_rise_w;
  logic si_w;
  logic wp_low_w;

  assign sck_rise_w = sck_s_q[1] & ~sck_s_q[2];
  assign sck_fall_w = ~sck_s_q[1] & sck_s_q[2];
  assign sel_w      = ~cs_s_q[1];
  assign cs_rise_w  = cs_s_q[1] & ~cs_s_q[2];
  assign si_w       = si_s_q[1];
  assign wp_low_w   = ~wp_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // serial receive: opcode and first data byte
  logic [2:0] bit_idx_q;
  logic [1:0] byte_cnt_q;
  logic [6:0] shift_in_q;
  logic [7:0] opcode_q;
  logic [7:0] data_q;
  logic [7:0] byte_w;

  assign byte_w = {shift_in_q, si_w};

  // mode 0 and 3 both sample on the rising edge; byte count saturates
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_idx_q  <= 3'h0;
      byte_cnt_q <= 2'h0;
      shift_in_q <= 7'h00;
      opcode_q   <= 8'h00;
      data_q     <= 8'h00;
    end else if (!sel_w) begin
      bit_idx_q  <= 3'h0;
      byte_cnt_q <= 2'h0;
    end else if (sck_rise_w) begin
      shift_in_q <= byte_w[6:0];
      bit_idx_q  <= bit_idx_q + 3'h1;
      if (bit_idx_q == 3'h7) begin
        if (byte_cnt_q == 2'h0) begin
          opcode_q <= byte_w;
        end
        if (byte_cnt_q == 2'h1) begin
          data_q <= byte_w;
        end
        if (byte_cnt_q != 2'h3) begin
          byte_cnt_q <= byte_cnt_q + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status state
  logic        busy_q;
  logic        wel_q;
  logic        susp_q;
  logic        prog_erase_q;
  logic        rst_en_q;
  logic [5:0]  nv_q;
  logic [31:0] busy_cnt_q;
  logic [7:0]  status_w;

  assign status_w = {nv_q, wel_q, busy_q};

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance at chip select release
  logic exec_w;
  logic clean_end_w;
  logic status_write_cmd_ok_w;
  logic gate_ok_w;
  logic accept_w;
  logic start_w;
  logic suspend_w;
  logic resume_w;
  logic sw_reset_w;
  logic done_w;

  // a command acts only when select rises on a byte boundary
  assign clean_end_w = (bit_idx_q == 3'h0) && (byte_cnt_q != 2'h0);
  assign exec_w      = cs_rise_w && clean_end_w;

  assign gate_ok_w   = wel_q || !is_gated(opcode_q);
  // hardware lock of the status write
  assign status_write_cmd_ok_w   = !(nv_q[flash_status_pkg::STATUS_LOCK_BIT - 2] && wp_low_w)
                       && (byte_cnt_q >= 2'h2);
  // nothing but reads, resets, suspend and resume while busy or suspended
  assign accept_w    = exec_w && !busy_q && !susp_q;
  // chip erase refused under any protection level
  assign start_w     = accept_w && is_gated(opcode_q) && gate_ok_w && !is_volatile(opcode_q)
                       && !(is_chip_erase(opcode_q) && (nv_q[3:0] != 4'h0))
                       && ((opcode_q != flash_status_pkg::OP_WRITE_STATUS) || status_write_cmd_ok_w);
  // suspend only during a program or erase
  assign suspend_w   = exec_w && busy_q && prog_erase_q && (opcode_q == flash_status_pkg::OP_SUSPEND);
  assign resume_w    = exec_w && susp_q && (opcode_q == flash_status_pkg::OP_RESUME);
  assign sw_reset_w  = exec_w && rst_en_q && (opcode_q == flash_status_pkg::OP_RESET);
  assign done_w      = busy_q && (busy_cnt_q == 32'h0);

  // reset-enable must be the command right before reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_en_q <= 1'b0;
    end else if (exec_w) begin
      rst_en_q <= (opcode_q == flash_status_pkg::OP_RESET_ENABLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal write cycle timer
  // busy runs a fixed count; suspend freezes the count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q       <= 1'b0;
      susp_q       <= 1'b0;
      prog_erase_q <= 1'b0;
      busy_cnt_q   <= 32'h0;
    end else if (sw_reset_w) begin
      busy_q <= 1'b0;
      susp_q <= 1'b0;
    end else if (start_w) begin
      busy_q       <= 1'b1;
      prog_erase_q <= is_prog_erase(opcode_q);
      busy_cnt_q   <= 32'(BUSY_CYCLES - 1);
    end else if (suspend_w) begin
      busy_q <= 1'b0;
      susp_q <= 1'b1;
    end else if (resume_w) begin
      busy_q <= 1'b1;
      susp_q <= 1'b0;
    end else if (done_w) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-enable latch
  // only latch commands, cycle end and software reset touch it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wel_q <= 1'b0;
    end else if (sw_reset_w || done_w) begin
      wel_q <= 1'b0;
    end else if (accept_w && (opcode_q == flash_status_pkg::OP_SET_WEL)) begin
      wel_q <= 1'b1;
    end else if (accept_w && (opcode_q == flash_status_pkg::OP_CLEAR_WEL)) begin
      wel_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection, four-line enable and lock bits
  // status write lands on bits 2..7 only; one copy serves both
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nv_q <= flash_status_pkg::STATUS_NV_RESET;
    end else if (start_w && (opcode_q == flash_status_pkg::OP_WRITE_STATUS)) begin
      nv_q <= data_q[flash_status_pkg::STATUS_LOCK_BIT:flash_status_pkg::PROT_LSB];
    end
  end

  assign four_line_enable = nv_q[flash_status_pkg::FOUR_LINE_BIT - 2];
  assign busy_flag        = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial transmit of the status byte
  logic [7:0] out_q;
  logic       so_q;
  logic       so_oe_q;
  logic       reading_w;

  assign reading_w = sel_w && (byte_cnt_q != 2'h0) && (opcode_q == flash_status_pkg::OP_READ_STATUS);

  // reload each byte so a long read repeats the register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_q   <= flash_status_pkg::STATUS_RESET;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!reading_w) begin
      so_oe_q <= 1'b0;
    end else if (sck_fall_w) begin
      so_oe_q <= 1'b1;
      if (bit_idx_q == 3'h0) begin
        out_q <= status_w;
        so_q  <= status_w[7];
      end else begin
        so_q  <= out_q[3'h7 - bit_idx_q];
      end
    end
  end

  assign so    = so_q;
  assign so_oe = so_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_gate_reject;
    exec_w && !busy_q && !susp_q && is_gated(opcode_q) && !wel_q |=> !busy_q && $stable(nv_q);
  endproperty
  a_gate_reject: assert property (p_gate_reject) else $error("gated write ran without latch");
  property p_set_latch;
    accept_w && (opcode_q == flash_status_pkg::OP_SET_WEL) |=> wel_q [*2];
  endproperty
  a_set_latch: assert property (p_set_latch) else $error("set-latch did not set latch");
  property p_clear_latch;
    accept_w && (opcode_q == flash_status_pkg::OP_CLEAR_WEL) |=> !wel_q;
  endproperty
  a_clear_latch: assert property (p_clear_latch) else $error("clear-latch did not clear latch");
  property p_done_clears;
    done_w |=> !busy_q && !wel_q;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("cycle end left busy or latch");
  // a command landing on the cycle's last clock sees the legal self-clear
  property p_busy_ignores;
    busy_q && exec_w && !done_w && (opcode_q != flash_status_pkg::OP_RESET) |=> $stable(wel_q) && $stable(nv_q);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("command acted while busy");
  property p_chip_erase_prot;
    exec_w && is_chip_erase(opcode_q) && (nv_q[3:0] != 4'h0) && !busy_q |=> !busy_q;
  endproperty
  a_chip_erase_prot: assert property (p_chip_erase_prot) else $error("chip erase under protection");
  property p_status_lock;
    exec_w && (opcode_q == flash_status_pkg::OP_WRITE_STATUS) && nv_q[5] && wp_low_w |=> $stable(nv_q);
  endproperty
  a_status_lock: assert property (p_status_lock) else $error("locked status was written");
  property p_status_write_cmd_keeps_latch;
    start_w && (opcode_q == flash_status_pkg::OP_WRITE_STATUS) |=> busy_q && wel_q && (nv_q == $past(data_q[7:2]));
  endproperty
  a_status_write_cmd_keeps_latch: assert property (p_status_write_cmd_keeps_latch) else $error("status write wrong");
  property p_volatile_no_latch;
    accept_w && ((opcode_q == flash_status_pkg::OP_RDPARAM_V) || (opcode_q == flash_status_pkg::OP_BANK_V))
      |=> !busy_q && $stable(wel_q);
  endproperty
  a_volatile_no_latch: assert property (p_volatile_no_latch) else $error("volatile write misbehaved");

endmodule

// ---- flash_host_model.sv ----
/*
 * host side of the serial link: frames instructions on chip select,
 * clock and data in, and collects what the device shifts out.
 * assumes a running sys_clk; the bench calls frame() hierarchically.
 */
`timescale 1ns/10ps
module flash_host_model (
  input  wire logic sys_clk,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // link idles with clock low and select high
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // half of the 80 ns link period, always on a falling system edge
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one frame, whole bytes only; rd keeps the last two bytes seen on so
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbytes,
                       output logic [15:0] rd);
    logic [7:0] b;
    rd   = 16'h0000;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < nbytes; i++) begin
      b = (i == 0) ? op : dat;
      for (int k = 7; k >= 0; k--) begin
        si = b[k];
        half();
        sck = 1'b1;
        // undriven output must never pass for data
        rd = {rd[14:0], (so_oe === 1'b1) ? so : 1'bx};
        half();
        sck = 1'b0;
      end
    end
    half();
    cs_n = 1'b1;
    si   = ~si; // no stale bit left after release
    half();
  endtask

endmodule

// ---- flash_status_and_write_enable_tb_top.sv ----
/*
 * self-checking bench for the status register and write-enable gate.
 * assumes the host model drives the link; busy time shortened to BUSY_N.
 */
`timescale 1ns/10ps
module flash_status_and_write_enable_tb_top;

  localparam int BUSY_N = 400;
  localparam int LIMIT  = 80000;

  logic        sys_clk = 1'b0;
  logic        resetn;
  logic        wp_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        four_line_enable;
  logic        busy_flag;
  logic [15:0] rd;
  int          fails;
  int          n_compared;
  int          cycles;

  // {busy expected once latched, opcode}; last eight leave the latch set
  logic [8:0] rows [40] = '{9'h102, 9'h112, 9'h132, 9'h138, 9'h134, 9'h13e, 9'h1d7, 9'h120,
    9'h121, 9'h152, 9'h15c, 9'h1d8, 9'h1dc, 9'h1c7, 9'h160, 9'h101, 9'h142, 9'h165, 9'h185,
    9'h164, 9'h162, 9'h118, 9'h143, 9'h1fd, 9'h1e3, 9'h1e4, 9'h12f, 9'h1a6, 9'h191, 9'h17e,
    9'h198, 9'h1e8, 9'h083, 9'h04a, 9'h0fb, 9'h0e1, 9'h0c0, 9'h063, 9'h017, 9'h0c5};

  ////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;

  flash_status_and_write_enable #(.BUSY_CYCLES(BUSY_N)) i_flash_status_and_write_enable (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .sck              (sck),
    .cs_n             (cs_n),
    .si               (si),
    .wp_n             (wp_n),
    .so               (so),
    .so_oe            (so_oe),
    .four_line_enable (four_line_enable),
    .busy_flag        (busy_flag)
  );

  flash_host_model i_flash_host_model (
    .sys_clk (sys_clk),
    .sck     (sck),
    .cs_n    (cs_n),
    .si      (si),
    .so      (so),
    .so_oe   (so_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // instruction plus one data byte; effects settle within a few clocks
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00);
    i_flash_host_model.frame(op, dat, 2, rd);
    repeat (2) @(negedge sys_clk);
  endtask

  // two status bytes read back to back must both match
  task automatic status(input logic [7:0] exp);
    i_flash_host_model.frame(8'h05, 8'h00, 3, rd);
    check("status", {exp, exp}, rd);
  endtask

  task automatic flag(input string what, input logic exp, input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask

  // bounded wait for the internal cycle to end
  task automatic wait_idle();
    int n = 0;
    while (busy_flag !== 1'b0 && n < BUSY_N + 20) begin
      @(negedge sys_clk);
      n++;
    end
    flag("idle", 1'b0, busy_flag);
  endtask

  // hang guard: long enough for all rows plus the hand tests
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("unexpected timeout: expected done seen running");
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    wp_n   = 1'b1;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    // each opcode without the latch, then with it, then latch cleared
    foreach (rows[r]) begin
      cmd(rows[r][7:0]);
      flag("busy_unlatched", 1'b0, busy_flag);
      cmd(8'h06);
      cmd(rows[r][7:0]);
      flag("busy_latched", rows[r][8], busy_flag);
      wait_idle();
      status(rows[r][8] ? 8'h00 : 8'h02);
      cmd(8'h04);
      status(8'h00);
      $display("row %0d op %h done", r, rows[r][7:0]);
    end
    // status write reaches bits 7:2 only
    cmd(8'h06);
    cmd(8'h01, 8'hff);
    wait_idle();
    status(8'hfc);
    flag("four_line", 1'b1, four_line_enable);
    // chip erase refused with protection set, latch kept
    cmd(8'h06);
    cmd(8'hc7);
    flag("busy_erase", 1'b0, busy_flag);
    // lock bit with pin low freezes the register
    wp_n = 1'b0;
    cmd(8'h01, 8'h00);
    status(8'hfe);
    wp_n = 1'b1;
    cmd(8'h01, 8'h00);
    wait_idle();
    status(8'h00);
    $display("test protect done");
    // while busy the clear-latch is ignored, reads still act
    cmd(8'h06);
    cmd(8'h02);
    cmd(8'h04);
    status(8'h03);
    wait_idle();
    status(8'h00);
    $display("test busy done");
    // suspend and resume an erase
    cmd(8'h06);
    cmd(8'h20);
    cmd(8'h75);
    flag("busy_suspended", 1'b0, busy_flag);
    status(8'h02);
    cmd(8'h7a);
    flag("busy_resumed", 1'b1, busy_flag);
    wait_idle();
    status(8'h00);
    $display("test suspend done");
    // software reset pair honoured while busy
    cmd(8'h06);
    cmd(8'h02);
    cmd(8'h66);
    cmd(8'h99);
    flag("busy_sw_reset", 1'b0, busy_flag);
    status(8'h00);
    $display("test soft reset done");
    // reset in mid cycle
    cmd(8'h06);
    cmd(8'h01, 8'hff);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    flag("busy_reset", 1'b0, busy_flag);
    flag("four_line_reset", 1'b0, four_line_enable);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    status(8'h00);
    $display("test reset done");
    complete_run();
  end

endmodule
